//--- pkg/pts_pkg.sv
// constants, opcodes and register map of the trigger sequencer
package pts_pkg;
	localparam int QDEPTH = 16;
	localparam int QAW    = 4;
	localparam int AW     = 8;

	// register byte offsets
	localparam logic [AW-1:0] OFS_CTRL  = 8'h00;
	localparam logic [AW-1:0] OFS_STAT  = 8'h04;
	localparam logic [AW-1:0] OFS_SDLIM = 8'h08;
	localparam logic [AW-1:0] OFS_C0LIM = 8'h0C;
	localparam logic [AW-1:0] OFS_C1LIM = 8'h10;
	localparam logic [AW-1:0] OFS_T0LIM = 8'h14;
	localparam logic [AW-1:0] OFS_T1LIM = 8'h18;
	localparam logic [AW-1:0] OFS_WDLIM = 8'h1C;
	localparam logic [AW-1:0] OFS_QUEUE = 8'h40;

	// control field positions
	localparam int B_EN    = 0;
	localparam int B_START = 1;
	localparam int B_SSTEP = 2;
	localparam int B_FALL  = 3;
	localparam int B_DIV   = 8;
	localparam int W_DIV   = 4;

	// status field positions
	localparam int B_PC   = 0;
	localparam int B_BUSY = 4;
	localparam int B_WAIT = 5;
	localparam int B_CNT0 = 16;

	// reset values
	localparam logic [15:0] RST_LIM  = 16'h0000;
	localparam logic [3:0]  RST_DIV  = 4'h0;

	// step command opcodes, upper nibble
	localparam logic [3:0] OP_NOP   = 4'h0;
	localparam logic [3:0] OP_WTRIG = 4'h1;
	localparam logic [3:0] OP_TRIG  = 4'h2;
	localparam logic [3:0] OP_WTMR  = 4'h3;
	localparam logic [3:0] OP_IRQ   = 4'h4;
	localparam logic [3:0] OP_JMPC0 = 4'h5;
	localparam logic [3:0] OP_JMPC1 = 4'h6;
	localparam logic [3:0] OP_JMP   = 4'h7;
	localparam logic [3:0] OP_HALT  = 4'h8;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_EXEC,
		ST_WAIT,
		ST_DELAY
	} pts_state_e;
endpackage

//--- pkg/pts_mem_if.sv
// queue memory carrier between sequencer and storage
`timescale 1ns/1ps
interface pts_mem_if;
	import pts_pkg::*;
	logic           wrEn;
	logic [QAW-1:0] wrAddr;
	logic [7:0]     wrData;
	logic [QAW-1:0] rdAddr;
	logic [7:0]     rdData;
	modport ctl (output wrEn, wrAddr, wrData, rdAddr, input rdData);
	modport mem (input wrEn, wrAddr, wrData, rdAddr, output rdData);
endinterface

//--- logic/pts_queue_mem.sv
// step queue storage with registered read data
`timescale 1ns/1ps
module pts_queue_mem
	import pts_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic nrst,
	// memory port
	pts_mem_if.mem    port
);
	logic [7:0] mem [QDEPTH];
	logic [7:0] rdData_r;

	always_ff @(posedge sys_clk) begin
		if (port.wrEn) begin
			mem[port.wrAddr] <= port.wrData;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rdData_r <= 8'h00;
		end else begin
			rdData_r <= mem[port.rdAddr];
		end
	end

	assign port.rdData = rdData_r;
endmodule

//--- logic/pts_sequencer.sv
// trigger sequencer top: apb registers, step engine, timers
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module pts_sequencer
	import pts_pkg::*;
#(
	parameter int TRIG_IN_W  = 8,
	parameter int TRIG_OUT_W = 8
)(
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  nrst,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [AW-1:0]         paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// peripheral triggers
	input  wire logic [TRIG_IN_W-1:0]  trigIn,
	output logic      [TRIG_OUT_W-1:0] trigOut,
	// processor requests and status
	output logic      [3:0]            irqReq,
	output logic                       stepIrq,
	output logic                       wdtIrq,
	output logic                       busy
);
	if (TRIG_IN_W < 6 || TRIG_IN_W > 16 || TRIG_OUT_W < 6 ||
			TRIG_OUT_W > 16) begin : g_chk
		$error("trigger widths must be 6 to 16");
	end

	function automatic logic sel16(input logic [15:0] v,
			input logic [3:0] i);
		sel16 = v[i];
	endfunction

	pts_mem_if qif ();
	pts_queue_mem u_mem (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.port    (qif.mem)
	);

	// control and limit registers
	logic             en_r, start_r, sstep_r, fall_r;
	logic [W_DIV-1:0] div_r;
	logic [15:0]      sdLim_r, c0Lim_r, c1Lim_r, t0Lim_r, t1Lim_r, wdLim_r;
	logic [31:0]      prdata_r;
	// engine state
	pts_state_e       st_r, st_nxt;
	logic [QAW-1:0]   pc_r, pc_nxt, npc_r, npc_nxt;
	logic [15:0]      sdCnt_r, sdCnt_nxt, wd_r, wd_nxt;
	logic [15:0]      t0_r, t0_nxt, t1_r, t1_nxt;
	logic [15:0]      c0_r, c0_nxt, c1_r, c1_nxt;
	logic [TRIG_OUT_W-1:0] tOut_r, tOut_nxt;
	logic [3:0]       irq_r, irq_nxt;
	logic             sIrq_r, sIrq_nxt, wIrq_r, wIrq_nxt, halt;
	logic [W_DIV-1:0] divCnt_r;
	logic [TRIG_IN_W-1:0] sync1_r, sync2_r, prev_r;
	logic             edgeLatch_r;

	// apb decode
	wire setup   = psel & ~penable;
	wire access  = psel & penable;
	wire wrAcc   = access & pwrite;
	wire isQueue = (paddr[AW-1:6] == OFS_QUEUE[AW-1:6]) && (paddr[1:0] == 2'b00);
	wire mapped  = isQueue || (paddr[AW-1:5] == 3'b000 && paddr[1:0] == 2'b00);
	wire wrCtrl  = wrAcc && paddr == OFS_CTRL;
	wire run     = en_r & start_r;
	wire locked  = run;
	wire wrSd    = wrAcc && paddr == OFS_SDLIM && !locked;
	wire wrC0    = wrAcc && paddr == OFS_C0LIM && !locked;
	wire wrC1    = wrAcc && paddr == OFS_C1LIM;
	wire wrT0    = wrAcc && paddr == OFS_T0LIM;
	wire wrT1    = wrAcc && paddr == OFS_T1LIM;
	wire wrWd    = wrAcc && paddr == OFS_WDLIM;
	wire tick    = (divCnt_r == div_r);
	wire [3:0] cmdOp  = qif.rdData[7:4];
	wire [3:0] cmdArg = qif.rdData[3:0];

	// trigger edge select
	wire [TRIG_IN_W-1:0] rise  = sync2_r & ~prev_r;
	wire [TRIG_IN_W-1:0] fall  = ~sync2_r & prev_r;
	wire [15:0] edgeVec = 16'(fall_r ? fall : rise);
	wire edgeNow = (st_r == ST_WAIT) && sel16(edgeVec, cmdArg);
	wire edgeAny = edgeNow | edgeLatch_r;

	assign qif.wrEn   = wrAcc & isQueue;
	assign qif.wrAddr = paddr[QAW+1:2];
	assign qif.wrData = pwdata[7:0];
	assign qif.rdAddr = pc_r;

	// register read mux
	wire [31:0] statWord = {c0_r, 10'h000, (st_r == ST_WAIT), run,
		pc_r};
	wire [31:0] ctrlWord = {20'h00000, div_r, 4'h0, fall_r, sstep_r,
		start_r, en_r};
	wire [31:0] rdMux =
		paddr == OFS_CTRL  ? ctrlWord :
		paddr == OFS_STAT  ? statWord :
		paddr == OFS_SDLIM ? {16'h0000, sdLim_r} :
		paddr == OFS_C0LIM ? {16'h0000, c0Lim_r} :
		paddr == OFS_C1LIM ? {16'h0000, c1Lim_r} :
		paddr == OFS_T0LIM ? {16'h0000, t0Lim_r} :
		paddr == OFS_T1LIM ? {16'h0000, t1Lim_r} :
		paddr == OFS_WDLIM ? {16'h0000, wdLim_r} : 32'h00000000;

	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata  = prdata_r;
	assign trigOut = tOut_r;
	assign irqReq  = irq_r;
	assign stepIrq = sIrq_r;
	assign wdtIrq  = wIrq_r;
	assign busy    = run;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			prdata_r <= 32'h00000000;
		end else if (setup) begin
			prdata_r <= rdMux;
		end
	end

	// control register; a start set beats a halt in the same cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			en_r    <= 1'b0;
			start_r <= 1'b0;
			sstep_r <= 1'b0;
			fall_r  <= 1'b0;
			div_r   <= RST_DIV;
		end else if (wrCtrl) begin
			en_r    <= pwdata[B_EN];
			start_r <= pwdata[B_START];
			sstep_r <= pwdata[B_SSTEP];
			fall_r  <= pwdata[B_FALL];
			div_r   <= pwdata[B_DIV +: W_DIV];
		end else if (halt) begin
			start_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sdLim_r <= RST_LIM;
			c0Lim_r <= RST_LIM;
			c1Lim_r <= RST_LIM;
			t0Lim_r <= RST_LIM;
			t1Lim_r <= RST_LIM;
			wdLim_r <= RST_LIM;
		end else begin
			if (wrSd) sdLim_r <= pwdata[15:0];
			if (wrC0) c0Lim_r <= pwdata[15:0];
			if (wrC1) c1Lim_r <= pwdata[15:0];
			if (wrT0) t0Lim_r <= pwdata[15:0];
			if (wrT1) t1Lim_r <= pwdata[15:0];
			if (wrWd) wdLim_r <= pwdata[15:0];
		end
	end

	// sequencer clock divider and trigger synchronisers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			divCnt_r    <= '0;
			sync1_r     <= '0;
			sync2_r     <= '0;
			prev_r      <= '0;
			edgeLatch_r <= 1'b0;
		end else begin
			divCnt_r    <= tick ? '0 : divCnt_r + 1'b1;
			sync1_r     <= trigIn;
			sync2_r     <= sync1_r;
			prev_r      <= sync2_r;
			edgeLatch_r <= (st_r == ST_WAIT) && (edgeNow || edgeLatch_r);
		end
	end

	// step engine next state
	always_comb begin
		st_nxt    = st_r;
		pc_nxt    = pc_r;
		npc_nxt   = npc_r;
		sdCnt_nxt = sdCnt_r;
		wd_nxt    = wd_r;
		t0_nxt    = t0_r;
		t1_nxt    = t1_r;
		c0_nxt    = c0_r;
		c1_nxt    = c1_r;
		tOut_nxt  = '0;
		irq_nxt   = 4'h0;
		sIrq_nxt  = 1'b0;
		wIrq_nxt  = 1'b0;
		halt      = 1'b0;
		if (!run) begin
			st_nxt = ST_IDLE;
		end else if (tick) begin
			case (st_r)
			ST_IDLE: begin
				st_nxt = ST_FETCH;
				pc_nxt = '0;
				c0_nxt = '0;
				c1_nxt = '0;
			end
			ST_FETCH: st_nxt = ST_EXEC;
			ST_EXEC: begin
				npc_nxt   = pc_r + 1'b1;
				sdCnt_nxt = '0;
				wd_nxt    = '0;
				st_nxt    = ST_DELAY;
				case (cmdOp)
				OP_WTRIG: st_nxt = ST_WAIT;
				OP_WTMR: begin
					st_nxt = ST_WAIT;
					t0_nxt = '0;
					t1_nxt = '0;
				end
				OP_TRIG: tOut_nxt = TRIG_OUT_W'(1) << cmdArg;
				OP_IRQ: irq_nxt = 4'h1 << cmdArg[1:0];
				OP_JMPC0: begin
					if (c0_r != c0Lim_r) begin
						c0_nxt  = c0_r + 16'h0001;
						npc_nxt = cmdArg;
					end else begin
						c0_nxt = '0;
					end
				end
				OP_JMPC1: begin
					if (c1_r != c1Lim_r) begin
						c1_nxt  = c1_r + 16'h0001;
						npc_nxt = cmdArg;
					end else begin
						c1_nxt = '0;
					end
				end
				OP_JMP: npc_nxt = cmdArg;
				OP_HALT: begin
					halt   = 1'b1;
					st_nxt = ST_IDLE;
				end
				default: ;
				endcase
			end
			ST_WAIT: begin
				wd_nxt = wd_r + 16'h0001;
				if (wdLim_r != 16'h0000 && wd_r == wdLim_r) begin
					wIrq_nxt = 1'b1;
					halt     = 1'b1;
					st_nxt   = ST_IDLE;
				end else if (cmdOp == OP_WTRIG) begin
					if (edgeAny) st_nxt = ST_DELAY;
				end else if (!cmdArg[0]) begin
					if (t0_r == t0Lim_r) st_nxt = ST_DELAY;
					else t0_nxt = t0_r + 16'h0001;
				end else begin
					if (t1_r == t1Lim_r) st_nxt = ST_DELAY;
					else t1_nxt = t1_r + 16'h0001;
				end
			end
			ST_DELAY: begin
				if (sdCnt_r == sdLim_r) begin
					st_nxt   = ST_FETCH;
					pc_nxt   = npc_r;
					sIrq_nxt = sstep_r;
				end else begin
					sdCnt_nxt = sdCnt_r + 16'h0001;
				end
			end
			default: st_nxt = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r    <= ST_IDLE;
			pc_r    <= '0;
			npc_r   <= '0;
			sdCnt_r <= '0;
			wd_r    <= '0;
			{t0_r, t1_r, c0_r, c1_r} <= '0;
			tOut_r  <= '0;
			irq_r   <= 4'h0;
			sIrq_r  <= 1'b0;
			wIrq_r  <= 1'b0;
		end else begin
			st_r    <= st_nxt;
			pc_r    <= pc_nxt;
			npc_r   <= npc_nxt;
			sdCnt_r <= sdCnt_nxt;
			wd_r    <= wd_nxt;
			{t0_r, t1_r, c0_r, c1_r} <= {t0_nxt, t1_nxt, c0_nxt, c1_nxt};
			tOut_r  <= tOut_nxt;
			irq_r   <= irq_nxt;
			sIrq_r  <= sIrq_nxt;
			wIrq_r  <= wIrq_nxt;
		end
	end

	// checks on engine behaviour
	a_sdlim_locked: assert property (@(posedge sys_clk) disable iff (!nrst)
		(run && wrAcc && paddr == OFS_SDLIM) |=> $stable(sdLim_r))
		else $error("step delay limit changed while running");
	a_c0lim_locked: assert property (@(posedge sys_clk) disable iff (!nrst)
		(run && wrAcc && paddr == OFS_C0LIM) |=> $stable(c0Lim_r))
		else $error("counter0 limit changed while running");
	a_delay_exit: assert property (@(posedge sys_clk) disable iff (!nrst)
		(run && tick && st_r == ST_DELAY && sdCnt_r == sdLim_r)
		|=> st_r == ST_FETCH && pc_r == $past(npc_r))
		else $error("delay did not end at its limit");
	a_delay_bound: assert property (@(posedge sys_clk) disable iff (!nrst)
		st_r == ST_DELAY |-> sdCnt_r <= sdLim_r)
		else $error("delay count passed its limit");
	a_next_ascend: assert property (@(posedge sys_clk) disable iff (!nrst)
		(run && tick && st_r == ST_EXEC && cmdOp == OP_NOP)
		|=> npc_r == $past(pc_r) + 4'h1)
		else $error("next entry is not the following one");
	a_trig_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
		trigOut != '0 |-> $past(st_r) == ST_EXEC ##1 trigOut == '0)
		else $error("trigger output not a single pulse");
	a_irq_cause: assert property (@(posedge sys_clk) disable iff (!nrst)
		irqReq != 4'h0 |-> $past(cmdOp) == OP_IRQ && $onehot(irqReq))
		else $error("interrupt request without its step");
	a_step_irq: assert property (@(posedge sys_clk) disable iff (!nrst)
		stepIrq |-> $past(sstep_r) && st_r == ST_FETCH)
		else $error("step interrupt outside single step");
	a_wdt_halt: assert property (@(posedge sys_clk) disable iff (!nrst)
		wdtIrq |-> st_r == ST_IDLE && !start_r)
		else $error("watchdog did not halt the sequence");
	a_jump_c0: assert property (@(posedge sys_clk) disable iff (!nrst)
		(run && tick && st_r == ST_EXEC && cmdOp == OP_JMPC0 &&
		c0_r != c0Lim_r) |=> npc_r == $past(cmdArg))
		else $error("counter0 jump not taken");
	c_trig_out: cover property (@(posedge sys_clk) disable iff (!nrst)
		trigOut != '0);
	c_jump_c0: cover property (@(posedge sys_clk) disable iff (!nrst)
		st_r == ST_EXEC && cmdOp == OP_JMPC0 && c0_r != c0Lim_r && tick);
	c_wdt: cover property (@(posedge sys_clk) disable iff (!nrst) wdtIrq);
	c_step_irq: cover property (@(posedge sys_clk) disable iff (!nrst)
		stepIrq);
endmodule

//--- verification/pts_periph_model.sv
// peripheral side model: drives trigger inputs, counts trigger pulses
`timescale 1ns/1ps
module pts_periph_model #(
	parameter int IW = 8,
	parameter int OW = 8
)(
	// clock and reset
	input  wire logic          sys_clk,
	input  wire logic          nrst,
	// levels requested by the bench
	input  wire logic [IW-1:0] lvl,
	// sequencer triggers
	input  wire logic [OW-1:0] trigOut,
	output logic      [IW-1:0] trigIn
);
	int cyc = 0;
	int cnt[OW] = '{default: 0};
	int lastCyc[OW] = '{default: 0};
	int prevCyc[OW] = '{default: 0};

	initial trigIn = '0;

	// sources change just after the clock, like on-chip flops
	always @(posedge sys_clk) begin
		trigIn <= nrst ? lvl : '0;
	end

	// one-clock pulses, time of the last two kept per line
	always @(posedge sys_clk) begin
		cyc++;
		for (int k = 0; k < OW; k++) begin
			if (trigOut[k] === 1'b1) begin
				cnt[k]++;
				prevCyc[k] = lastCyc[k];
				lastCyc[k] = cyc;
			end
		end
	end
endmodule

//--- verification/testbench.sv
// self-checking bench of the trigger sequencer
`timescale 1ns/1ps
module testbench;
	import pts_pkg::*;
	logic        sys_clk, nrst, psel, penable, pwrite;
	logic [7:0]  paddr, trigIn, trigOut, lvl;
	logic [31:0] pwdata, prdata, rv;
	logic        pready, pslverr, stepIrq, wdtIrq, busy, er;
	logic [3:0]  irqReq;
	logic [31:0] seed = 32'h06F4C633;
	logic [7:0]  prog[$];
	int          n_fail = 0;
	int          num_checks = 0;
	int          irqCnt[4] = '{default: 0};
	int          stepCnt = 0;
	int          wdtCnt = 0;
	int          wdtCyc = 0;
	int          d, t, n, i, j, c0, s0, base;
	int          snap[12];

	pts_sequencer i_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trigIn(trigIn), .trigOut(trigOut),
		.irqReq(irqReq), .stepIrq(stepIrq), .wdtIrq(wdtIrq), .busy(busy));
	pts_periph_model i_per (.sys_clk(sys_clk), .nrst(nrst), .lvl(lvl),
		.trigOut(trigOut), .trigIn(trigIn));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		for (int m = 0; m < 4; m++)
			if (irqReq[m] === 1'b1) irqCnt[m]++;
		if (stepIrq === 1'b1) stepCnt++;
		if (wdtIrq === 1'b1) begin
			wdtCnt++;
			wdtCyc = i_per.cyc;
		end
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// clocks between two pulses that lie the given steps apart
	function automatic int step_gap(input int steps, input int dly,
		input int dv);
		return steps * (dly + 3) * (dv + 1);
	endfunction

	task automatic print_verdict();
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %0h exp %0h", $time,
				msg, got, exp);
		end
	endtask

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) chk(0, 1, "apb hang");
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input string msg);
		apb(1'b0, a, 32'h0000_0000);
		chk(rv, e, msg);
	endtask

	task automatic load();
		for (int q = 0; q < prog.size(); q++)
			wr(OFS_QUEUE + 8'(4 * q), 32'(prog[q]));
	endtask

	task automatic go(input logic [31:0] c);
		wr(OFS_CTRL, c);
	endtask

	// wait for the halt step, then disable
	task automatic fin();
		int k;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (busy === 1'b1 && k < 3000);
		if (k >= 3000) chk(0, 1, "run hang");
		wr(OFS_CTRL, 32'h0000_0000);
	endtask

	initial begin
		#400000;
		n_fail++;
		print_verdict();
	end

	initial begin
		nrst = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		lvl = 8'h00;
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		rdc(OFS_SDLIM, 0, "delay limit reset");
		rdc(OFS_C0LIM, 0, "counter0 limit reset");
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk(er, 1, "unmapped error");
		rdc(OFS_QUEUE, 0, "queue write only");
		// step spacing, boundary zero then random; lock while running
		for (j = 0; j < 2; j++) begin
			d = j ? 64 + (xs() & 63) : 0;
			wr(OFS_SDLIM, d);
			rdc(OFS_SDLIM, d, "delay limit");
			prog = '{8'h20, 8'h20, 8'h80};
			load();
			go(3);
			if (j) begin
				wr(OFS_SDLIM, 5);
				wr(OFS_C0LIM, 7);
				rdc(OFS_SDLIM, d, "delay limit locked");
				rdc(OFS_C0LIM, 0, "counter0 limit locked");
			end
			fin();
			n = i_per.lastCyc[0] - i_per.prevCyc[0];
			chk(n, step_gap(1, d, 0), "gap");
		end
		wr(OFS_SDLIM, 0);
		// loop counts on both limit counters
		for (j = 0; j < 2; j++) begin
			n = 1 + (xs() & 3);
			wr(j ? OFS_C1LIM : OFS_C0LIM, n);
			rdc(j ? OFS_C1LIM : OFS_C0LIM, n, "limit write");
			prog = '{8'h21, j ? 8'h60 : 8'h50, 8'h80};
			load();
			c0 = i_per.cnt[1];
			go(3);
			fin();
			chk(i_per.cnt[1] - c0, n + 1, "loop count");
		end
		// every irq line and output lines 0 to 5, single-step off then on
		prog = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h20, 8'h21, 8'h22,
			8'h23, 8'h24, 8'h25, 8'h80};
		load();
		for (j = 0; j < 2; j++) begin
			for (i = 0; i < 8; i++) snap[i] = i_per.cnt[i];
			for (i = 0; i < 4; i++) snap[8 + i] = irqCnt[i];
			s0 = stepCnt;
			go(3 | (j << 2));
			fin();
			for (i = 0; i < 6; i++)
				chk(i_per.cnt[i] - snap[i], 1, "trig out");
			for (i = 0; i < 4; i++)
				chk(irqCnt[i] - snap[8 + i], 1, "irq");
			chk(stepCnt > s0, j, "step irq");
		end
		// edge wait: wrong edge ignored, right edge releases
		for (j = 0; j < 2; j++) begin
			i = xs() % 6;
			lvl[i] <= !j;
			prog = '{8'h10 | 8'(i), 8'h23, 8'h80};
			load();
			c0 = i_per.cnt[3];
			go(3 | (j << 3));
			lvl[i] <= j[0];
			repeat (20) @(posedge sys_clk);
			rdc(OFS_STAT, (1 << B_WAIT) | (1 << B_BUSY), "status");
			chk(i_per.cnt[3] - c0, 0, "wrong edge");
			lvl[i] <= !j;
			fin();
			chk(i_per.cnt[3] - c0, 1, "edge wait");
		end
		// timed waits on both timers
		for (j = 0; j < 2; j++) begin
			t = 10 + (xs() & 31);
			wr(j ? OFS_T1LIM : OFS_T0LIM, t);
			prog = '{8'h20, 8'h30 | 8'(j), 8'h20, 8'h80};
			load();
			go(3);
			fin();
			n = i_per.lastCyc[0] - i_per.prevCyc[0];
			chk(n > t && n <= t + 10, 1, "timer wait");
		end
		// divided sequencer clock, jump over a halt onto a no-op
		d = 1 + (xs() & 7);
		prog = '{8'h20, 8'h73, 8'h80, 8'h00, 8'h20, 8'h80};
		load();
		c0 = i_per.cnt[0];
		go(3 | (d << 8));
		rdc(OFS_CTRL, 3 | (d << 8), "control readback");
		fin();
		chk(i_per.cnt[0] - c0, 2, "jump taken");
		n = i_per.lastCyc[0] - i_per.prevCyc[0];
		chk(n, step_gap(3, 0, d), "divided gap");
		// watchdog ends a wait that never completes
		n = 8 + (xs() & 7);
		wr(OFS_WDLIM, n);
		prog = '{8'h17, 8'h20, 8'h80};
		load();
		s0 = wdtCnt;
		c0 = i_per.cnt[0];
		go(3);
		base = i_per.cyc;
		fin();
		chk(wdtCnt - s0, 1, "watchdog irq");
		chk(wdtCyc - base >= n, 1, "watchdog time");
		chk(i_per.cnt[0] - c0, 0, "halted after timeout");
		wr(OFS_WDLIM, 0);
		print_verdict();
	end
endmodule
